// ### hw/ccu_top.sv
`timescale 1ns/1ps
module ccu_top (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset,
  // axi4-lite write address
  input  wire logic [7:0]                s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read
  input  wire logic [7:0]                s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // timers and adc
  input  wire ccu_pkg::ccu_timer_in_t    timer_in,
  output ccu_pkg::ccu_trigger_out_t      trigger_out,
  // unit pin
  input  wire logic                      unit_pin_in,
  output logic                           unit_pin_out,
  output logic                           unit_pin_oe,
  // interrupt
  output logic                           irq
);
  import ccu_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [5:0]  unit_two_control;
  logic [7:0]  duty_high_byte;
  logic [15:0] pair;
  logic        event_flag;
  logic        event_mask;
  logic [9:0]  duty_active;
  logic [3:0]  prescale;
  logic        match_q;
  logic        cmp_latch;
  logic        pwm_level;
  logic        aw_held, w_held;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;

  logic [5:0]  next_unit_two_control;
  logic [7:0]  next_duty_high_byte;
  logic [15:0] next_pair;
  logic        next_event_flag, next_event_mask;
  logic [9:0]  next_duty_active;
  logic [3:0]  next_prescale;
  logic        next_match_q, next_cmp_latch, next_pwm_level;
  logic        next_aw_held, next_w_held, next_awready, next_wready, next_arready;
  logic [7:0]  next_aw_addr;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        next_pin_out, next_pin_oe, next_irq;
  ccu_trigger_out_t next_trigger;

  logic        pin_rise, pin_fall;
  ccu_mode_t   mode;
  logic        is_cap, is_cmp, is_pwm;
  logic        cap_fire, cmp_hit, match_now;
  logic        do_write;
  logic [31:0] wr_word;

  // ****************************************
  // pin edge detection
  // ****************************************
  ccu_pin_sync u_sync (
    .clock  (clock),
    .reset  (reset),
    .pin_in (unit_pin_in),
    .rise   (pin_rise),
    .fall   (pin_fall)
  );

  // merge the write data into the old word under the byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w,
                                        input logic [31:0] new_w,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************
  // mode decode
  // ****************************************
  // reserved codes fall in no group, so nothing below acts on them
  always_comb begin
    mode   = ccu_mode_t'(unit_two_control[CTL_MODE_MSB:0]);
    is_cap = (unit_two_control[CTL_MODE_MSB -: 2] == GRP_CAPTURE);
    is_cmp = (unit_two_control[CTL_MODE_MSB -: 2] == GRP_COMPARE);
    is_pwm = (unit_two_control[CTL_MODE_MSB -: 2] == GRP_PWM);
  end

  // ****************************************
  // capture, compare and pwm
  // ****************************************
  // capture and compare watch the first timer, pwm the second
  always_comb begin
    cap_fire = 1'b0;
    unique case (mode)
      MODE_CAP_FALL: cap_fire = pin_fall;
      MODE_CAP_RISE: cap_fire = pin_rise;
      MODE_CAP_4:    cap_fire = pin_rise && prescale == PRE4_LAST;
      MODE_CAP_16:   cap_fire = pin_rise && prescale == PRE16_LAST;
      default:       cap_fire = 1'b0;
    endcase
    // match edge only, so a held match fires once
    match_now = is_cmp && (timer_in.first_timer_count == pair);
    cmp_hit   = match_now && !match_q;

    next_match_q = match_now;
    next_prescale = prescale;
    if (!is_cap) begin
      next_prescale = '0;
    end else if (cap_fire) begin
      next_prescale = '0;
    end else if (pin_rise) begin
      next_prescale = prescale + 4'h1;
    end

    next_cmp_latch = cmp_latch;
    next_trigger   = '0;
    if (mode == MODE_OFF) begin
      next_cmp_latch = 1'b0;
    end else if (cmp_hit) begin
      unique case (mode)
        MODE_CMP_SET: next_cmp_latch = 1'b1;
        MODE_CMP_CLR: next_cmp_latch = 1'b0;
        MODE_CMP_TRIG: begin
          next_trigger.first_timer_reset = 1'b1;
          next_trigger.adc_start         = timer_in.adc_enable;
        end
        default: next_cmp_latch = cmp_latch;
      endcase
    end

    // period end reloads the duty and raises the pin unless duty is zero
    next_duty_active = duty_active;
    next_pwm_level   = pwm_level;
    if (!is_pwm) begin
      next_pwm_level = 1'b0;
    end else if (timer_in.second_timer_period_end) begin
      next_duty_active = {duty_high_byte, unit_two_control[CTL_DC_MSB:CTL_DC_LSB]};
      next_pwm_level   = (next_duty_active != DUTY_ZERO);
    end else if (timer_in.second_timer_count >= duty_active) begin
      next_pwm_level = 1'b0;
    end

    // compare-only and trigger modes leave the pin undriven
    next_pin_oe  = is_pwm || mode == MODE_CMP_SET || mode == MODE_CMP_CLR;
    next_pin_out = is_pwm ? next_pwm_level : next_cmp_latch;
  end

  // ****************************************
  // axi4-lite slave and registers
  // ****************************************
  // address and data are held until both are in, either order
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    do_write = aw_held && w_held && !s_axi_bvalid;
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end

    next_unit_two_control = unit_two_control;
    next_duty_high_byte   = duty_high_byte;
    next_pair             = pair;
    next_event_mask       = event_mask;
    next_event_flag       = event_flag;
    next_bresp            = s_axi_bresp;
    next_bvalid           = s_axi_bvalid && !s_axi_bready;
    wr_word               = '0;
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = RESP_OKAY;
      unique case (aw_addr)
        OFS_CONTROL: begin
          wr_word = merge({26'h0, unit_two_control}, w_data, w_strb);
          next_unit_two_control = wr_word[5:0];
        end
        OFS_DUTY_HI: begin
          wr_word = merge({24'h0, duty_high_byte}, w_data, w_strb);
          next_duty_high_byte = wr_word[7:0];
        end
        OFS_PAIR: begin
          wr_word = merge({16'h0, pair}, w_data, w_strb);
          next_pair = wr_word[15:0];
        end
        OFS_STATUS: begin
          if (w_strb[0] && w_data[STAT_EVENT]) begin
            next_event_flag = 1'b0;
          end
        end
        OFS_MASK: begin
          if (w_strb[0]) begin
            next_event_mask = w_data[STAT_EVENT];
          end
        end
        default: next_bresp = RESP_SLVERR;
      endcase
    end
    // hardware events win over a same-cycle clear or write
    if (cap_fire) begin
      next_pair = timer_in.first_timer_count;
    end
    if (cap_fire || cmp_hit) begin
      next_event_flag = 1'b1;
    end
    next_irq = next_event_flag && next_event_mask;

    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_CONTROL:  next_rdata = {26'h0, unit_two_control};
        OFS_DUTY_HI:  next_rdata = {24'h0, duty_high_byte};
        OFS_PAIR:     next_rdata = {16'h0, pair};
        OFS_STATUS:   next_rdata = {31'h0, event_flag};
        OFS_MASK:     next_rdata = {31'h0, event_mask};
        OFS_DUTY_ACT: next_rdata = {22'h0, duty_active};
        default: begin
          next_rdata = '0;
          next_rresp = RESP_SLVERR;
        end
      endcase
    end
  end

  // awready and wready follow the next held state, arready the next rvalid, so each port leaves a flip-flop
  always_comb begin
    next_awready = !next_aw_held;
    next_wready  = !next_w_held;
    next_arready = !next_rvalid;
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      unit_two_control <= CTL_RESET;
      duty_high_byte   <= DUTY_RESET;
      pair             <= PAIR_RESET;
      event_flag       <= 1'b0;
      event_mask       <= 1'b0;
      duty_active      <= DUTY_ZERO;
      prescale         <= '0;
      match_q          <= 1'b0;
      cmp_latch        <= 1'b0;
      pwm_level        <= 1'b0;
      aw_held          <= 1'b0;
      aw_addr          <= '0;
      w_held           <= 1'b0;
      w_data           <= '0;
      w_strb           <= '0;
      s_axi_awready    <= 1'b1;
      s_axi_wready     <= 1'b1;
      s_axi_arready    <= 1'b1;
      s_axi_bvalid     <= 1'b0;
      s_axi_bresp      <= RESP_OKAY;
      s_axi_rvalid     <= 1'b0;
      s_axi_rdata      <= '0;
      s_axi_rresp      <= RESP_OKAY;
      unit_pin_out     <= 1'b0;
      unit_pin_oe      <= 1'b0;
      trigger_out      <= '0;
      irq              <= 1'b0;
    end else begin
      unit_two_control <= next_unit_two_control;
      duty_high_byte   <= next_duty_high_byte;
      pair             <= next_pair;
      event_flag       <= next_event_flag;
      event_mask       <= next_event_mask;
      duty_active      <= next_duty_active;
      prescale         <= next_prescale;
      match_q          <= next_match_q;
      cmp_latch        <= next_cmp_latch;
      pwm_level        <= next_pwm_level;
      aw_held          <= next_aw_held;
      aw_addr          <= next_aw_addr;
      w_held           <= next_w_held;
      w_data           <= next_w_data;
      w_strb           <= next_w_strb;
      s_axi_awready    <= next_awready;
      s_axi_wready     <= next_wready;
      s_axi_arready    <= next_arready;
      s_axi_bvalid     <= next_bvalid;
      s_axi_bresp      <= next_bresp;
      s_axi_rvalid     <= next_rvalid;
      s_axi_rdata      <= next_rdata;
      s_axi_rresp      <= next_rresp;
      unit_pin_out     <= next_pin_out;
      unit_pin_oe      <= next_pin_oe;
      trigger_out      <= next_trigger;
      irq              <= next_irq;
    end
  end

endmodule // ccu_top

// ### hw/ccu_pkg.sv
package ccu_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_DUTY_HI  = 8'h04;
  localparam logic [7:0] OFS_PAIR     = 8'h08;
  localparam logic [7:0] OFS_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_MASK     = 8'h10;
  localparam logic [7:0] OFS_DUTY_ACT = 8'h14;

  // ****************************************
  // control fields and reset values
  // ****************************************
  localparam int        CTL_DC_LSB   = 4;
  localparam int        CTL_DC_MSB   = 5;
  localparam int        CTL_MODE_MSB = 3;
  localparam logic [5:0] CTL_RESET    = 6'h00;
  localparam logic [7:0] DUTY_RESET   = 8'h00;
  localparam logic [15:0] PAIR_RESET  = 16'h0000;
  localparam int        STAT_EVENT   = 0;

  // ****************************************
  // mode codes and groups
  // ****************************************
  typedef enum logic [3:0] {
    MODE_OFF      = 4'h0,
    MODE_RSV1     = 4'h1,
    MODE_RSV2     = 4'h2,
    MODE_RSV3     = 4'h3,
    MODE_CAP_FALL = 4'h4,
    MODE_CAP_RISE = 4'h5,
    MODE_CAP_4    = 4'h6,
    MODE_CAP_16   = 4'h7,
    MODE_CMP_SET  = 4'h8,
    MODE_CMP_CLR  = 4'h9,
    MODE_CMP_SW   = 4'hA,
    MODE_CMP_TRIG = 4'hB,
    MODE_PWM0     = 4'hC,
    MODE_PWM1     = 4'hD,
    MODE_PWM2     = 4'hE,
    MODE_PWM3     = 4'hF
  } ccu_mode_t;

  localparam logic [1:0] GRP_CAPTURE = 2'h1;
  localparam logic [1:0] GRP_COMPARE = 2'h2;
  localparam logic [1:0] GRP_PWM     = 2'h3;
  localparam logic [3:0] PRE4_LAST   = 4'h3;
  localparam logic [3:0] PRE16_LAST  = 4'hF;
  localparam logic [9:0] DUTY_ZERO   = 10'h000;

  // ****************************************
  // axi responses
  // ****************************************
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic [15:0] first_timer_count;
    logic [9:0]  second_timer_count;
    logic        second_timer_period_end;
    logic        adc_enable;
  } ccu_timer_in_t;

  typedef struct packed {
    logic first_timer_reset;
    logic adc_start;
  } ccu_trigger_out_t;

endpackage

// ### hw/ccu_pin_sync.sv
`timescale 1ns/1ps
module ccu_pin_sync (
  // clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // pin and edge pulses
  input  wire logic pin_in,
  output logic      rise,
  output logic      fall
);
  import ccu_pkg::*;

  logic s1, s2, s3, level;
  logic next_level;

  // a change counts only once the second and third stages agree
  always_comb begin
    next_level = level;
    if (s2 == s3) begin
      next_level = s3;
    end
    rise = next_level & ~level;
    fall = ~next_level & level;
  end

  // three-stage synchroniser; s1 is read by s2 alone
  always_ff @(posedge clock) begin
    if (reset) begin
      s1    <= 1'b0;
      s2    <= 1'b0;
      s3    <= 1'b0;
      level <= 1'b0;
    end else begin
      s1    <= pin_in;
      s2    <= s1;
      s3    <= s2;
      level <= next_level;
    end
  end

endmodule // ccu_pin_sync

// ### sim/ccu_top_sva.sv
`timescale 1ns/1ps
module ccu_chk (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     reset,
  // register bus
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  // unit side
  input wire ccu_pkg::ccu_timer_in_t   timer_in,
  input wire ccu_pkg::ccu_trigger_out_t trigger_out,
  input wire logic                     unit_pin_oe,
  input wire logic                     irq
);
  import ccu_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  // ****************************************
  // bus handshake
  // ****************************************
  // a write is only answered while its address is held
  aw_busy_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready))
    else $error("write response without a held address");
  rv_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated after its handshake");
  ar_gate_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read not answered on the next cycle");
  rv_cause_a: assert property ($rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("read data without an accepted address");

  // ****************************************
  // unit behaviour
  // ****************************************
  trig_pulse_a: assert property (trigger_out.first_timer_reset |=>
    !trigger_out.first_timer_reset)
    else $error("timer reset trigger longer than one cycle");
  adc_gate_a: assert property (trigger_out.adc_start |->
    trigger_out.first_timer_reset && $past(timer_in.adc_enable))
    else $error("conversion start without trigger or enable");
  trig_nopin_a: assert property (trigger_out.first_timer_reset |-> !unit_pin_oe)
    else $error("pin driven in special event mode");
  // irq, bvalid and the pin enable must come out of reset quiet
  rst_quiet_a: assert property ($past(reset) |-> !irq && !s_axi_bvalid && !unit_pin_oe)
    else $error("outputs active right after reset");

  trig_c: cover property (trigger_out.adc_start);
  irq_c: cover property ($rose(irq));
  slverr_c: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule // ccu_chk

// ### sim/ccu_pin_model.sv
`timescale 1ns/1ps
module ccu_pin_model (
  // clock
  input wire logic clock,
  // level the bench asks for
  input wire logic level,
  // unit side of the pin
  input wire logic unit_pin_out,
  input wire logic unit_pin_oe,
  output logic     wire_level
);
  logic src;

  // the source moves its line only just after a clock edge
  always_ff @(posedge clock) begin
    src <= level;
  end

  // wired pin: the unit wins while it drives, else the source
  assign wire_level = unit_pin_oe ? unit_pin_out : src;
endmodule // ccu_pin_model

// ### sim/ccu_top_test.sv
`timescale 1ns/1ps
module ccu_top_test;
  import ccu_pkg::*;
  typedef struct {
    logic [7:0]  a;
    logic [31:0] w;
    logic [31:0] r;
    logic [1:0]  wr;
    logic [1:0]  rr;
  } ccu_row_t;

  logic clock, reset, awv, awr, wv, wrdy, bv, arv, arr, rv, level;
  logic pin_in, pin_out, pin_oe, irq;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  ccu_timer_in_t tin;
  ccu_trigger_out_t tout;
  int miscompares, cmp_count, trig_n, adc_n;
  logic [3:0] cm [7] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'hA, 4'hB};
  ccu_row_t rows [7] = '{
    '{OFS_CONTROL, 32'hFF, 32'h3F, RESP_OKAY, RESP_OKAY},
    '{OFS_CONTROL, 32'h13, 32'h13, RESP_OKAY, RESP_OKAY},
    '{OFS_DUTY_HI, 32'hA5, 32'hA5, RESP_OKAY, RESP_OKAY},
    '{OFS_PAIR, 32'h1234ABCD, 32'hABCD, RESP_OKAY, RESP_OKAY},
    '{OFS_MASK, 32'hFFFFFFFF, 32'h1, RESP_OKAY, RESP_OKAY},
    '{OFS_DUTY_ACT, 32'h5, 32'h0, RESP_SLVERR, RESP_OKAY},
    '{8'h18, 32'h5, 32'h0, RESP_SLVERR, RESP_SLVERR}};

  ccu_top DUT (.clock(clock), .reset(reset),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
    .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(1'b1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(1'b1),
    .timer_in(tin), .trigger_out(tout), .unit_pin_in(pin_in),
    .unit_pin_out(pin_out), .unit_pin_oe(pin_oe), .irq(irq));
  ccu_pin_model src (.clock(clock), .level(level), .unit_pin_out(pin_out),
    .unit_pin_oe(pin_oe), .wire_level(pin_in));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // trigger pulses counted off the falling edge to avoid a race
  always @(negedge clock) begin
    if (tout.first_timer_reset) trig_n++;
    if (tout.adc_start) adc_n++;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic stop_test;
    if (miscompares == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // flags are looked at mid-cycle, once the edge has settled
  task automatic chkb(input logic g, input logic e);
    @(negedge clock);
    chk({31'h0, g}, {31'h0, e});
    @(posedge clock);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clock);
  endtask

  task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ah, wh, bh;
    logic [1:0] rs;
    int n;
    awaddr <= a;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    n = 0;
    bh = 1'b0;
    while (!bh) begin
      @(negedge clock);
      ah = awv && awr;
      wh = wv && wrdy;
      bh = bv;
      rs = bresp;
      @(posedge clock);
      if (ah) awv <= 1'b0;
      if (wh) wv <= 1'b0;
      if (++n > 40) begin
        miscompares++;
        stop_test;
      end
    end
    chk({30'h0, rs}, {30'h0, er});
  endtask

  task automatic get(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ah, rh;
    logic [31:0] d;
    logic [1:0] rs;
    int n;
    araddr <= a;
    arv <= 1'b1;
    n = 0;
    rh = 1'b0;
    while (!rh) begin
      @(negedge clock);
      ah = arv && arr;
      rh = rv;
      d = rdata;
      rs = rresp;
      @(posedge clock);
      if (ah) arv <= 1'b0;
      if (++n > 40) begin
        miscompares++;
        stop_test;
      end
    end
    chk(d, e);
    chk({30'h0, rs}, {30'h0, er});
  endtask

  // n pin pulses; the flag may only rise on the last rising or falling edge
  task automatic cap(input logic [3:0] m, input int n, input logic f);
    put(OFS_CONTROL, 32'h0, RESP_OKAY);
    put(OFS_CONTROL, {28'h0, m}, RESP_OKAY);
    put(OFS_STATUS, 32'h1, RESP_OKAY);
    for (int i = 1; i <= n; i++) begin
      tin.first_timer_count <= 16'h1000 + 16'(i);
      level <= 1'b1;
      idle(8);
      get(OFS_STATUS, {31'h0, !f && i == n}, RESP_OKAY);
      level <= 1'b0;
      idle(8);
    end
    get(OFS_STATUS, 32'h1, RESP_OKAY);
    get(OFS_PAIR, 32'h1000 + n, RESP_OKAY);
    chkb(irq, 1'b1);
  endtask

  // mode 1001 keeps the latch left high by 1000, so no off between them
  task automatic cmp(input logic [3:0] m);
    if (m != 4'h9) put(OFS_CONTROL, 32'h0, RESP_OKAY);
    tin.first_timer_count <= 16'h01FF;
    put(OFS_PAIR, 32'h0200, RESP_OKAY);
    put(OFS_CONTROL, {28'h0, m}, RESP_OKAY);
    put(OFS_STATUS, 32'h1, RESP_OKAY);
    trig_n = 0;
    adc_n = 0;
    chkb(pin_out, m == 4'h9);
    tin.first_timer_count <= 16'h0200;
    idle(4);
    get(OFS_STATUS, {31'h0, m[3]}, RESP_OKAY);
    chkb(pin_oe, m == 4'h8 || m == 4'h9);
    chkb(pin_out, m == 4'h8);
    chk(trig_n, m == 4'hB);
    chk(adc_n, m == 4'hB && tin.adc_enable);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    awv = 1'b0;
    wv = 1'b0;
    arv = 1'b0;
    level = 1'b0;
    tin = '0;
    tin.adc_enable = 1'b1;
    miscompares = 0;
    cmp_count = 0;
    idle(10);
    reset <= 1'b0;
    for (int k = 0; k < 6; k++) get(8'(4 * k), 32'h0, RESP_OKAY);
    foreach (rows[i]) begin
      put(rows[i].a, rows[i].w, rows[i].wr);
      get(rows[i].a, rows[i].r, rows[i].rr);
    end
    cap(4'h4, 1, 1'b1);
    cap(4'h5, 1, 1'b0);
    cap(4'h6, 4, 1'b0);
    cap(4'h7, 16, 1'b0);
    put(OFS_MASK, 32'h0, RESP_OKAY);
    chkb(irq, 1'b0);
    put(OFS_MASK, 32'h1, RESP_OKAY);
    chkb(irq, 1'b1);
    put(OFS_STATUS, 32'h1, RESP_OKAY);
    chkb(irq, 1'b0);
    for (int k = 0; k < 7; k++) cmp(cm[k]);
    // special event with the converter disabled must not start it
    tin.adc_enable <= 1'b0;
    cmp(4'hB);
    // pwm: duty moves to the active copy only at the period end
    put(OFS_DUTY_HI, 32'h40, RESP_OKAY);
    put(OFS_CONTROL, 32'h2C, RESP_OKAY);
    get(OFS_DUTY_ACT, 32'h0, RESP_OKAY);
    tin.second_timer_count <= 10'h000;
    tin.second_timer_period_end <= 1'b1;
    idle(1);
    tin.second_timer_period_end <= 1'b0;
    idle(2);
    chkb(pin_out, 1'b1);
    get(OFS_DUTY_ACT, 32'h102, RESP_OKAY);
    put(OFS_DUTY_HI, 32'h10, RESP_OKAY);
    get(OFS_DUTY_ACT, 32'h102, RESP_OKAY);
    tin.second_timer_count <= 10'h101;
    chkb(pin_out, 1'b1);
    tin.second_timer_count <= 10'h102;
    idle(2);
    chkb(pin_out, 1'b0);
    for (int m = 13; m < 16; m++) begin
      put(OFS_CONTROL, 32'h20 + m, RESP_OKAY);
      chkb(pin_oe, 1'b1);
    end
    // second reset in mid-run
    reset <= 1'b1;
    idle(3);
    reset <= 1'b0;
    chkb(irq, 1'b0);
    for (int k = 0; k < 6; k++) get(8'(4 * k), 32'h0, RESP_OKAY);
    stop_test;
  end

  initial begin
    idle(60000);
    miscompares++;
    stop_test;
  end
endmodule // ccu_top_test

bind ccu_top ccu_chk chk_i (.clock(clock), .reset(reset),
  .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .timer_in(timer_in), .trigger_out(trigger_out), .unit_pin_oe(unit_pin_oe), .irq(irq));
